// file: common/rptc_pkg.sv
// Constants, register map and state type of the radio power timing block.
// Assumes an 8-bit register port and a 25 MHz system clock.
package rptc_pkg;
   // Register byte addresses
   localparam logic [15:0] ADDR_RADIO_PWR = 16'hdf17;
   localparam logic [15:0] ADDR_TIMING_HI = 16'hdf20;
   localparam logic [15:0] ADDR_TIMING_LO = 16'hdf21;
   localparam logic [15:0] ADDR_MASK_HI   = 16'hdf22;
   localparam logic [15:0] ADDR_MASK_LO   = 16'hdf23;
   // Reset values
   localparam logic [7:0] RADIO_PWR_RST = 8'h0c;
   localparam logic [7:0] TIMING_HI_RST = 8'h7a;
   localparam logic [7:0] TIMING_LO_RST = 8'h94;
   localparam logic [7:0] MASK_HI_RST   = 8'hff;
   localparam logic [7:0] MASK_LO_RST   = 8'h7f;
   // Radio power register fields
   localparam int PWR_STATUS_BIT = 4;
   localparam int PWR_REGOFF_BIT = 3;
   localparam int PWR_DELAY_MSB  = 2;
   // Timing high fields
   localparam int TH_RXCHAIN_LSB = 5;
   localparam int TH_AMPLEAD_LSB = 2;
   localparam int TH_SWHI_MSB    = 1;
   // Timing low fields
   localparam int TL_SWLO_LSB    = 6;
   localparam int TL_SWOFF_LSB   = 3;
   localparam int TL_AMPOFF_LSB  = 0;
   // Mask high fields
   localparam int MH_PEAKRST_BIT = 7;
   localparam int MH_BIAS_BIT    = 6;
   localparam int MH_EXTBIAS_BIT = 5;
   localparam int MH_BUFSEL_BIT  = 4;
   localparam int MH_PRESC_BIT   = 3;
   localparam int MH_AMPNEG_BIT  = 2;
   localparam int MH_AMPPOS_BIT  = 1;
   localparam int MH_TXCONV_BIT  = 0;
   // Mask low fields
   localparam int ML_CALOSC_BIT  = 6;
   localparam int ML_CHPUMP_BIT  = 5;
   localparam int ML_SYNTH_BIT   = 4;
   localparam int ML_RXCONV_BIT  = 3;
   localparam int ML_GAIN_BIT    = 2;
   localparam int ML_RXFILT_BIT  = 1;
   localparam int ML_FRONT_BIT   = 0;
   localparam logic [7:0] MASK_LO_USED = 8'h7f;
   // Timing
   localparam int CLK_PERIOD_NS = 40;
   localparam int TICK_NS       = 1000;
   localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
   localparam int RX_STEP_US    = 5;
   localparam int HALF_SYMBOL_US   = 8;
   localparam int CAL_HALF_SYMBOLS = 13;
   localparam int CAL_US = CAL_HALF_SYMBOLS * HALF_SYMBOL_US;
   localparam int SEQ_W = 7;
   localparam int REG_W = 11;
   localparam logic [REG_W-1:0] REG_DELAY_US [8] = '{
      11'h000, 11'h01f, 11'h03f, 11'h07d,
      11'h0fa, 11'h1f4, 11'h3e8, 11'h7d0};
   typedef enum logic [2:0] {
      ST_IDLE, ST_CAL, ST_RXCHAIN, ST_RXON,
      ST_TXLEAD, ST_TXON, ST_TXTAIL
   } rptc_state_type;
endpackage : rptc_pkg

// file: common/rptc_timer_if.sv
// Link between the sequencer and one microsecond elapsed-time counter.
// Assumes start and tick come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface rptc_timer_if #(parameter int W = 7);
   logic         start;
   logic         tick;
   logic [W-1:0] elapsed;
   modport owner (output start, output tick, input elapsed);
   modport timer (input start, input tick, output elapsed);
endinterface : rptc_timer_if
`default_nettype wire

// file: src/rptc_us_timer.sv
// Saturating counter of microsecond ticks since the last start.
// Assumes a one-cycle tick and a start that may be held as a clear.
`timescale 1ns/100ps
`default_nettype none
module rptc_us_timer #(
   parameter int W = 7
) (
   input wire logic   clock,
   input wire logic   nrst,
   rptc_timer_if.timer tmr
);
   // Saturation keeps a long wait from wrapping back below its limit
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         tmr.elapsed <= '0;
      end else if (tmr.start) begin
         tmr.elapsed <= '0;
      end else if (tmr.tick && !(&tmr.elapsed)) begin
         tmr.elapsed <= tmr.elapsed + 1'b1;
      end
   end
endmodule : rptc_us_timer
`default_nettype wire

// file: src/rptc_radio_power_timing.sv
// Power state sequencer for the analog radio section with register port.
// Assumes request inputs come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// [RL1] Read-only bit 4 follows regulator bit after the programmed delay.
// [RL2] While delayed status is 0 every analog block stays powered down.
// [RL3] Bit 3 powers regulator up at 0, down at 1; resets to 1.
// [RL4] Delay code selects 0..2000 us; resets to code 100.
// [RL5] Demodulator waits field times 5 us after receive chain start.
// [RL6] Receive chain starts only after 6.5 symbol filter calibration.
// [RL7] Amplifier powers up field microseconds before transmission.
// [RL8] Switch goes high a split 4-bit microsecond count before transmit.
// [RL9] Switch drops a 3-bit microsecond delay after the last chip.
// [RL10] Amplifier and modulator stop a 3-bit delay after last chip.
// [RL11] High mask gates prescaler, amp paths, transmit converter; both paths off.
// [RL12] High mask bit 5 selects external amplifier bias via switch.
// [RL13] High mask bit 4 selects oscillator or amplifier buffers.
// [RL14] High mask bit 7 drives active-low peak detector reset.
// [RL15] Low mask bits 6..0 gate seven receive and synth blocks.
// [RL16] Each mask bit except high mask bit 6, which gates nothing, ANDs its control; 0 forces it low.
// [RL17] All waits count one shared microsecond tick from their event.
module rptc_radio_power_timing
   import rptc_pkg::*;
#(
   parameter int unsigned TickCycles = TICK_CYCLES
) (
   input  wire logic        clock,
   input  wire logic        nrst,
   input  wire logic [15:0] addr,
   input  wire logic [7:0]  wrData,
   input  wire logic        wrEn,
   input  wire logic        rdEn,
   output logic      [7:0]  rdData,
   input  wire logic        rxRequest,
   input  wire logic        txRequest,
   input  wire logic        lastChipSent,
   output logic             regulatorOff,
   output logic             radioAnalogOnDelayed,
   output logic             demodEnable,
   output logic             modulatorEnable,
   output logic             ampExternalBiasSelect,
   output logic             ampBufferSelect,
   output logic             gainAmpPeakRstN,
   output logic             globalBiasOff,
   output logic             prescalerOff,
   output logic             ampNegOff,
   output logic             ampPosOff,
   output logic             upMixerOff,
   output logic             txConverterOff,
   output logic             rxFilterCalOscOff,
   output logic             chargePumpOff,
   output logic             synthOff,
   output logic             rxConverterOff,
   output logic             gainAmpOff,
   output logic             rxFilterOff,
   output logic             frontEndOff
);
   localparam logic [15:0] TickLast = 16'(TickCycles - 1);

   logic [7:0]       pwr_q;
   logic [7:0]       timHi_q;
   logic [7:0]       timLo_q;
   logic [7:0]       maskHi_q;
   logic [7:0]       maskLo_q;
   logic             status_q;
   logic [15:0]      tickCnt_q;
   logic             tick_q;
   rptc_state_type   state_q;
   rptc_state_type   state_d;
   logic [2:0]       regDelayCode;
   logic [2:0]       rxChainTime;
   logic [2:0]       ampLeadTime;
   logic [3:0]       switchLeadTime;
   logic [2:0]       swOffTime;
   logic [2:0]       ampOffTime;
   logic [3:0]       leadTotal;
   logic [SEQ_W-1:0] seqElapsed;
   logic             ampCtl;
   logic             swCtl;
   logic             modCtl;
   logic             rxPath;
   logic             busy;

   rptc_timer_if #(.W(REG_W)) regTmr ();
   rptc_timer_if #(.W(SEQ_W)) seqTmr ();

   rptc_us_timer #(.W(REG_W)) uRegTimer (
      .clock (clock),
      .nrst  (nrst),
      .tmr   (regTmr.timer)
   );
   rptc_us_timer #(.W(SEQ_W)) uSeqTimer (
      .clock (clock),
      .nrst  (nrst),
      .tmr   (seqTmr.timer)
   );

   assign regDelayCode   = pwr_q[PWR_DELAY_MSB:0];
   assign rxChainTime    = timHi_q[TH_RXCHAIN_LSB+:3];
   assign ampLeadTime    = timHi_q[TH_AMPLEAD_LSB+:3];
   assign switchLeadTime = {timHi_q[TH_SWHI_MSB:0], timLo_q[TL_SWLO_LSB+:2]}; // RL8
   assign swOffTime      = timLo_q[TL_SWOFF_LSB+:3];
   assign ampOffTime     = timLo_q[TL_AMPOFF_LSB+:3];
   assign regulatorOff   = pwr_q[PWR_REGOFF_BIT];
   assign radioAnalogOnDelayed = status_q;
   assign seqElapsed     = seqTmr.elapsed;

   // Register writes
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         pwr_q    <= RADIO_PWR_RST; // RL3 RL4
         timHi_q  <= TIMING_HI_RST;
         timLo_q  <= TIMING_LO_RST;
         maskHi_q <= MASK_HI_RST;
         maskLo_q <= MASK_LO_RST; // RL15
      end else if (wrEn) begin
         case (addr)
            ADDR_RADIO_PWR: pwr_q    <= {4'h0, wrData[3:0]};
            ADDR_TIMING_HI: timHi_q  <= wrData;
            ADDR_TIMING_LO: timLo_q  <= wrData;
            ADDR_MASK_HI:   maskHi_q <= wrData;
            ADDR_MASK_LO:   maskLo_q <= wrData & MASK_LO_USED;
            default:        ;
         endcase
      end
   end

   // Read data stands for the one cycle after the strobe only
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rdData <= 8'h00;
      end else if (!rdEn) begin
         rdData <= 8'h00;
      end else begin
         case (addr)
            ADDR_RADIO_PWR: rdData <= {3'h0, status_q, pwr_q[3:0]}; // RL1
            ADDR_TIMING_HI: rdData <= timHi_q;
            ADDR_TIMING_LO: rdData <= timLo_q;
            ADDR_MASK_HI:   rdData <= maskHi_q;
            ADDR_MASK_LO:   rdData <= maskLo_q;
            default:        rdData <= 8'h00;
         endcase
      end
   end

   // One microsecond tick shared by every wait
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         tickCnt_q <= 16'h0000;
         tick_q    <= 1'b0;
      end else if (tickCnt_q >= TickLast) begin
         tickCnt_q <= 16'h0000; // RL17
         tick_q    <= 1'b1;
      end else begin
         tickCnt_q <= tickCnt_q + 16'h0001;
         tick_q    <= 1'b0;
      end
   end

   // Regulator timer is held clear while the regulator is off
   assign regTmr.tick  = tick_q;
   assign regTmr.start = pwr_q[PWR_REGOFF_BIT]; // RL17

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         status_q <= 1'b0;
      end else begin
         status_q <= !pwr_q[PWR_REGOFF_BIT] &&
            regTmr.elapsed >= REG_DELAY_US[regDelayCode]; // RL1 RL4
      end
   end

   // Transmit lead: the longer lead starts at once, the shorter one later
   assign leadTotal = (switchLeadTime > {1'b0, ampLeadTime}) ?
                      switchLeadTime : {1'b0, ampLeadTime};
   assign busy   = state_q != ST_IDLE;
   assign rxPath = state_q == ST_RXCHAIN || state_q == ST_RXON;

   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (status_q && txRequest) begin
               state_d = ST_TXLEAD;
            end else if (status_q && rxRequest) begin
               state_d = ST_CAL; // RL6
            end
         end
         ST_CAL: begin
            if (txRequest) begin
               state_d = ST_TXLEAD;
            end else if (!rxRequest) begin
               state_d = ST_IDLE;
            end else if (seqElapsed >= SEQ_W'(CAL_US)) begin
               state_d = ST_RXCHAIN; // RL6
            end
         end
         ST_RXCHAIN: begin
            if (txRequest) begin
               state_d = ST_TXLEAD;
            end else if (!rxRequest) begin
               state_d = ST_IDLE;
            end else if (seqElapsed >=
                         SEQ_W'(rxChainTime * RX_STEP_US)) begin
               state_d = ST_RXON; // RL5
            end
         end
         ST_RXON: begin
            if (txRequest) begin
               state_d = ST_TXLEAD;
            end else if (!rxRequest) begin
               state_d = ST_IDLE;
            end
         end
         ST_TXLEAD: begin
            if (seqElapsed >= SEQ_W'(leadTotal)) begin
               state_d = ST_TXON; // RL7 RL8
            end
         end
         ST_TXON: begin
            if (lastChipSent) begin
               state_d = ST_TXTAIL;
            end
         end
         ST_TXTAIL: begin
            if (seqElapsed >= SEQ_W'(swOffTime) &&
                seqElapsed >= SEQ_W'(ampOffTime)) begin
               state_d = ST_IDLE;
            end
         end
         default: state_d = ST_IDLE;
      endcase
      // Losing the regulator aborts any sequence
      if (!status_q) begin
         state_d = ST_IDLE;
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state_q <= ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // Each wait restarts on the edge that enters its state
   assign seqTmr.tick  = tick_q;
   assign seqTmr.start = state_d != state_q; // RL17

   always_comb begin
      ampCtl = 1'b0;
      swCtl  = 1'b0;
      modCtl = 1'b0;
      case (state_q)
         ST_TXLEAD: begin
            ampCtl = seqElapsed >= SEQ_W'(leadTotal - {1'b0, ampLeadTime}); // RL7
            swCtl  = seqElapsed >= SEQ_W'(leadTotal - switchLeadTime); // RL8
         end
         ST_TXON: begin
            ampCtl = 1'b1;
            swCtl  = 1'b1;
            modCtl = 1'b1;
         end
         ST_TXTAIL: begin
            swCtl  = seqElapsed < SEQ_W'(swOffTime); // RL9
            ampCtl = seqElapsed < SEQ_W'(ampOffTime); // RL10
            modCtl = seqElapsed < SEQ_W'(ampOffTime); // RL10
         end
         default: ;
      endcase
   end

   // Outputs: power-downs forced high until the delayed status rises
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         demodEnable           <= 1'b0;
         modulatorEnable       <= 1'b0;
         ampExternalBiasSelect <= 1'b0;
         ampBufferSelect       <= 1'b0;
         gainAmpPeakRstN       <= 1'b0;
         globalBiasOff         <= 1'b1;
         prescalerOff          <= 1'b1;
         ampNegOff             <= 1'b1;
         ampPosOff             <= 1'b1;
         upMixerOff            <= 1'b1;
         txConverterOff        <= 1'b1;
         rxFilterCalOscOff     <= 1'b1;
         chargePumpOff         <= 1'b1;
         synthOff              <= 1'b1;
         rxConverterOff        <= 1'b1;
         gainAmpOff            <= 1'b1;
         rxFilterOff           <= 1'b1;
         frontEndOff           <= 1'b1;
      end else begin
         demodEnable     <= status_q && state_q == ST_RXON; // RL5
         modulatorEnable <= status_q && modCtl; // RL10
         ampExternalBiasSelect <= status_q && swCtl &&
            maskHi_q[MH_EXTBIAS_BIT]; // RL12 RL16
         ampBufferSelect <= status_q && (state_q >= ST_TXLEAD) &&
            maskHi_q[MH_BUFSEL_BIT]; // RL13 RL16
         gainAmpPeakRstN <= status_q && state_q == ST_RXON &&
            maskHi_q[MH_PEAKRST_BIT]; // RL14 RL16
         // Bias is needed whenever the regulator is up
         globalBiasOff  <= !status_q; // RL2
         prescalerOff   <= !status_q ||
            (!busy && maskHi_q[MH_PRESC_BIT]); // RL2 RL11 RL16
         ampNegOff      <= !status_q ||
            (!ampCtl && maskHi_q[MH_AMPNEG_BIT]); // RL11 RL16
         ampPosOff      <= !status_q ||
            (!ampCtl && maskHi_q[MH_AMPPOS_BIT]); // RL11 RL16
         upMixerOff     <= !status_q || (!ampCtl &&
            maskHi_q[MH_AMPNEG_BIT] && maskHi_q[MH_AMPPOS_BIT]); // RL11
         txConverterOff <= !status_q ||
            (!modCtl && maskHi_q[MH_TXCONV_BIT]); // RL11 RL16
         rxFilterCalOscOff <= !status_q || (state_q != ST_CAL &&
            maskLo_q[ML_CALOSC_BIT]); // RL15 RL16
         chargePumpOff  <= !status_q ||
            (!busy && maskLo_q[ML_CHPUMP_BIT]); // RL15
         synthOff       <= !status_q ||
            (!busy && maskLo_q[ML_SYNTH_BIT]); // RL15
         rxConverterOff <= !status_q ||
            (!rxPath && maskLo_q[ML_RXCONV_BIT]); // RL15
         gainAmpOff     <= !status_q ||
            (!rxPath && maskLo_q[ML_GAIN_BIT]); // RL15
         rxFilterOff    <= !status_q || (!rxPath && state_q != ST_CAL &&
            maskLo_q[ML_RXFILT_BIT]); // RL15
         frontEndOff    <= !status_q ||
            (!rxPath && maskLo_q[ML_FRONT_BIT]); // RL2 RL15 RL16
      end
   end

   // Checks
   chk_status_follow_off: assert property ( // RL1
      @(posedge clock) disable iff (!nrst)
      pwr_q[PWR_REGOFF_BIT] |=> !radioAnalogOnDelayed)
      else $error("delayed status high while regulator off");

   chk_zero_delay_up: assert property ( // RL4
      @(posedge clock) disable iff (!nrst)
      ($fell(pwr_q[PWR_REGOFF_BIT]) && regDelayCode == 3'h0 &&
       $stable(regDelayCode)) ##1 !pwr_q[PWR_REGOFF_BIT]
      |-> radioAnalogOnDelayed)
      else $error("zero delay code did not raise status at once");

   chk_status_delay_min: assert property ( // RL4
      @(posedge clock) disable iff (!nrst)
      $rose(status_q) |->
      $past(regTmr.elapsed) >= REG_DELAY_US[$past(regDelayCode)])
      else $error("status rose before the regulator delay");

   chk_all_forced_off: assert property ( // RL2
      @(posedge clock) disable iff (!nrst)
      !status_q |=> frontEndOff && synthOff && ampPosOff && ampNegOff &&
      rxFilterOff && gainAmpOff && rxConverterOff && txConverterOff &&
      !modulatorEnable && !demodEnable)
      else $error("analog block enabled while radio is off");

   chk_cal_before_rx: assert property ( // RL6
      @(posedge clock) disable iff (!nrst)
      (state_q == ST_RXCHAIN && $changed(state_q)) |->
      $past(state_q) == ST_CAL &&
      $past(seqElapsed) >= SEQ_W'(CAL_US))
      else $error("receive chain started without calibration");

   chk_demod_wait: assert property ( // RL5
      @(posedge clock) disable iff (!nrst)
      (state_q == ST_RXON && $past(state_q) == ST_RXCHAIN) |->
      $past(seqElapsed) >= SEQ_W'($past(rxChainTime) * RX_STEP_US))
      else $error("demodulator enabled too early");

   chk_mixer_both_off: assert property ( // RL11
      @(posedge clock) disable iff (!nrst)
      (status_q && maskHi_q[MH_AMPNEG_BIT] && maskHi_q[MH_AMPPOS_BIT])
      ##1 (ampNegOff && ampPosOff) |-> upMixerOff)
      else $error("up mixers on with both amplifier paths off");

   chk_mask_forces_low: assert property ( // RL16
      @(posedge clock) disable iff (!nrst)
      (status_q && !maskLo_q[ML_FRONT_BIT]) |=> !frontEndOff)
      else $error("cleared mask bit did not force control low");

   chk_amp_on_at_tx: assert property ( // RL7
      @(posedge clock) disable iff (!nrst)
      $rose(modulatorEnable) |-> !ampPosOff && !ampNegOff)
      else $error("transmit started with amplifier off");

   chk_switch_tail_off: assert property ( // RL9
      @(posedge clock) disable iff (!nrst)
      (state_q == ST_TXTAIL && seqElapsed >= SEQ_W'(swOffTime))
      |=> !ampExternalBiasSelect)
      else $error("switch still high after tail delay");

   cov_rx_reached: cover property (
      @(posedge clock) disable iff (!nrst) $rose(demodEnable));
   cov_tx_tail: cover property (
      @(posedge clock) disable iff (!nrst)
      state_q == ST_TXON ##1 state_q == ST_TXTAIL);
   cov_status_up: cover property (
      @(posedge clock) disable iff (!nrst) $rose(status_q));
endmodule : rptc_radio_power_timing
`default_nettype wire

// file: dv/rptc_front_end_model.sv
// Transmit side of the analog front end: answers with a last chip pulse.
// Assumes modulatorEnable stays high from transmit start to amp-off time.
`timescale 1ns/100ps
`default_nettype none
module rptc_front_end_model #(
   parameter int ChipCycles = 40
) (
   input  wire logic clock,
   input  wire logic nrst,
   input  wire logic modulatorEnable,
   output var  logic lastChipSent
);
   int chipCount_q;
   // Count saturates so each packet gives exactly one last chip pulse
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         chipCount_q  <= 0;
         lastChipSent <= 1'b0;
      end else begin
         lastChipSent <= modulatorEnable && chipCount_q == ChipCycles - 1;
         if (!modulatorEnable) chipCount_q <= 0;
         else if (chipCount_q < ChipCycles) chipCount_q <= chipCount_q + 1;
      end
   end
endmodule : rptc_front_end_model
`default_nettype wire

// file: dv/tb_rptc_radio_power_timing.sv
// Bench for the radio power timing block: registers, regulator, rx, tx.
// Assumes the front end model closes every transmit with a last chip.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
   $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb_rptc_radio_power_timing;
   import rptc_pkg::*;
   // Short tick keeps the 2000 us regulator wait affordable
   localparam int TCK = 4;
   logic        clock, nrst, wrEn, rdEn, rxRequest, txRequest, lastChipSent;
   logic [15:0] addr;
   logic [7:0]  wrData, rdData, got;
   logic        regulatorOff, radioAnalogOnDelayed, demodEnable;
   logic        modulatorEnable, ampExternalBiasSelect, ampBufferSelect;
   logic        gainAmpPeakRstN, globalBiasOff, prescalerOff, ampNegOff;
   logic        ampPosOff, upMixerOff, txConverterOff, rxFilterCalOscOff;
   logic        chargePumpOff, synthOff, rxConverterOff, gainAmpOff;
   logic        rxFilterOff, frontEndOff;
   int          bad_count, num_checks, cyc, t0, n0, tStat, tDemod, swRises;
   int          tSwOn, tSwOff, tAmpOn, tModOn, tModOff, tLast;
   logic [15:0] ra [6] = '{16'hdf17, 16'hdf20, 16'hdf21, 16'hdf22,
                           16'hdf23, 16'hdf18};
   logic [7:0]  rv [6] = '{8'h0c, 8'h7a, 8'h94, 8'hff, 8'h7f, 8'h00};
   int          regUs [8] = '{0, 31, 63, 125, 250, 500, 1000, 2000};
   logic [7:0]  loVal [3] = '{8'h94, 8'h29, 8'h94};
   logic [7:0]  mhVal [3] = '{8'hff, 8'hff, 8'hdf};
   int          swLead [3] = '{10, 8, 10};
   int          swOffUs [3] = '{2, 5, 2};
   int          ampOffUs [3] = '{4, 1, 4};
   wire [6:0]   lowOffs = {rxFilterCalOscOff, chargePumpOff, synthOff,
                           rxConverterOff, gainAmpOff, rxFilterOff, frontEndOff};
   wire [12:0]  offs = {globalBiasOff, prescalerOff, ampNegOff, ampPosOff,
                        upMixerOff, txConverterOff, lowOffs};
   wire [4:0]   txOffs = {prescalerOff, ampNegOff, ampPosOff, upMixerOff,
                          txConverterOff};

   rptc_radio_power_timing #(.TickCycles(TCK)) uut (
      .clock, .nrst, .addr, .wrData, .wrEn, .rdEn, .rdData, .rxRequest,
      .txRequest, .lastChipSent, .regulatorOff, .radioAnalogOnDelayed,
      .demodEnable, .modulatorEnable, .ampExternalBiasSelect,
      .ampBufferSelect, .gainAmpPeakRstN, .globalBiasOff, .prescalerOff,
      .ampNegOff, .ampPosOff, .upMixerOff, .txConverterOff,
      .rxFilterCalOscOff, .chargePumpOff, .synthOff, .rxConverterOff,
      .gainAmpOff, .rxFilterOff, .frontEndOff);
   rptc_front_end_model #(.ChipCycles(40)) peer (
      .clock, .nrst, .modulatorEnable, .lastChipSent);

   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   // Event times; the analog blocks must stay down while status is low
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if ($rose(radioAnalogOnDelayed)) tStat <= cyc;
      if ($rose(demodEnable)) tDemod <= cyc;
      if ($rose(ampExternalBiasSelect)) tSwOn <= cyc;
      if ($rose(ampExternalBiasSelect)) swRises <= swRises + 1;
      if ($fell(ampExternalBiasSelect)) tSwOff <= cyc;
      if ($fell(ampPosOff)) tAmpOn <= cyc;
      if ($rose(modulatorEnable)) tModOn <= cyc;
      if ($fell(modulatorEnable)) tModOff <= cyc;
      if (lastChipSent) tLast <= cyc;
      if (nrst && !radioAnalogOnDelayed && !$past(radioAnalogOnDelayed))
         `CHK(offs, 13'h1fff)
   end

   function automatic logic near(input int m, input int us);
      return m >= us * TCK - 2 * TCK - 3 && m <= us * TCK + TCK + 3;
   endfunction : near

   function automatic logic sig(input int k);
      case (k)
         0: return radioAnalogOnDelayed;
         1: return demodEnable;
         2: return modulatorEnable;
         default: return !demodEnable && !modulatorEnable
                         && !ampExternalBiasSelect;
      endcase
   endfunction : sig

   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : finish_test

   task automatic waitSig(input int k, input int lim);
      int n;
      n = 0;
      while (sig(k) !== 1'b1 && n < lim) begin
         @(posedge clock);
         #1 n++;
      end
      if (n >= lim) begin
         bad_count++;
         $display("[FAIL] %0t wait %0d timed out", $time, k);
         finish_test();
      end else begin
         // One more edge so the event recorders and lagging outputs catch up
         @(posedge clock);
         #1;
      end
   endtask : waitSig

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clock);
      addr   <= a;
      wrData <= d;
      wrEn   <= 1'b1;
      @(posedge clock);
      wrEn <= 1'b0;
      #1;
   endtask : wr

   task automatic rd(input logic [15:0] a);
      @(posedge clock);
      addr <= a;
      rdEn <= 1'b1;
      @(posedge clock);
      rdEn <= 1'b0;
      #1 got = rdData;
   endtask : rd

   // Outputs are registered behind the register, so allow two edges
   task automatic settle();
      repeat (2) @(posedge clock);
      #1;
   endtask : settle

   initial begin
      {nrst, wrEn, rdEn, rxRequest, txRequest, addr, wrData} = '0;
      repeat (5) @(posedge clock);
      nrst <= 1'b1;
      #1;
      `CHK({regulatorOff, radioAnalogOnDelayed}, 2'b10)
      for (int i = 0; i < 6; i++) begin
         rd(ra[i]);
         `CHK(got, rv[i])
      end
      wr(16'hdf17, 8'hfc);
      wr(16'hdf18, 8'haa);
      rd(16'hdf17);
      `CHK(got, 8'h0c)
      rd(16'hdf18);
      `CHK(got, 8'h00)
      $display("test registers done");
      for (int c = 0; c < 8; c++) begin
         wr(16'hdf17, 8'h08 | 8'(c));
         wr(16'hdf17, 8'(c));
         t0 = cyc;
         `CHK(regulatorOff, 1'b0)
         waitSig(0, 2100 * TCK);
         `CHK(near(tStat - t0, regUs[c]), 1'b1)
         rd(16'hdf17);
         `CHK(got, 8'h10 | 8'(c))
      end
      $display("test regulator done");
      wr(16'hdf23, 8'h00);
      settle();
      `CHK(lowOffs, 7'h00)
      wr(16'hdf23, 8'hff);
      settle();
      `CHK(lowOffs, 7'h7f)
      rd(16'hdf23);
      `CHK(got, 8'h7f)
      wr(16'hdf22, 8'hf2);
      settle();
      `CHK(txOffs, 5'b00100)
      wr(16'hdf22, 8'hff);
      settle();
      `CHK(txOffs, 5'b11111)
      $display("test masks done");
      for (int f = 0; f < 8; f += 7) begin
         wr(16'hdf20, {3'(f), 5'h1a});
         @(posedge clock);
         rxRequest <= 1'b1;
         #1 t0 = cyc;
         settle();
         `CHK({rxFilterCalOscOff, frontEndOff, demodEnable}, 3'b010)
         waitSig(1, 300 * TCK);
         `CHK(near(tDemod - t0, 104 + 5 * f), 1'b1)
         `CHK({frontEndOff, gainAmpPeakRstN}, 2'b01)
         wr(16'hdf22, 8'h7f);
         settle();
         `CHK(gainAmpPeakRstN, 1'b0)
         wr(16'hdf22, 8'hff);
         @(posedge clock);
         rxRequest <= 1'b0;
         waitSig(3, 20);
      end
      $display("test receive done");
      wr(16'hdf20, 8'h7a);
      for (int r = 0; r < 3; r++) begin
         wr(16'hdf21, loVal[r]);
         wr(16'hdf22, mhVal[r]);
         n0 = swRises;
         @(posedge clock);
         txRequest <= 1'b1;
         waitSig(2, 40 * TCK);
         txRequest <= 1'b0;
         `CHK(ampBufferSelect, 1'b1)
         `CHK(near(tModOn - tAmpOn, 6), 1'b1)
         waitSig(3, 20 * TCK + 60);
         `CHK(ampBufferSelect, 1'b0)
         `CHK(near(tModOff - tLast, ampOffUs[r]), 1'b1)
         if (r < 2) begin
            `CHK(near(tModOn - tSwOn, swLead[r]), 1'b1)
            `CHK(near(tSwOff - tLast, swOffUs[r]), 1'b1)
         end else
            `CHK(swRises, n0)
      end
      $display("test transmit done");
      wr(16'hdf23, 8'h00);
      wr(16'hdf22, 8'h00);
      wr(16'hdf17, 8'h08);
      settle();
      settle();
      `CHK({regulatorOff, radioAnalogOnDelayed, offs}, 15'h5fff)
      $display("test power off done");
      finish_test();
   end
endmodule : tb_rptc_radio_power_timing
`default_nettype wire
